// ===== srap_cfg.svh
// Constants of the serial register access port: offsets, masks, defaults.
// Assumes inclusion by bare name from the package and the core.
`ifndef SRAP_CFG_SVH
`define SRAP_CFG_SVH

// Register offsets
`define SRAP_PART_IDENTITY_REVISION 8'h00
`define SRAP_FUSE_IMAGE_VERSION 8'h01
`define SRAP_STEP_DOWN0_MODE_ENABLE 8'h02
`define SRAP_STEP_DOWN0_LIMIT_SLEW 8'h03
`define SRAP_STEP_DOWN1_MODE_ENABLE 8'h04
`define SRAP_STEP_DOWN1_LIMIT_SLEW 8'h05
`define SRAP_STEP_DOWN0_VOLTAGE 8'h06
`define SRAP_STEP_DOWN1_VOLTAGE 8'h07
`define SRAP_LINEAR0_ENABLE 8'h08
`define SRAP_LINEAR1_ENABLE 8'h09
`define SRAP_LINEAR0_VOLTAGE 8'h0a
`define SRAP_LINEAR1_VOLTAGE 8'h0b
`define SRAP_STEP_DOWN0_SEQUENCE_DELAYS 8'h0c
`define SRAP_STEP_DOWN1_SEQUENCE_DELAYS 8'h0d
`define SRAP_LINEAR0_SEQUENCE_DELAYS 8'h0e
`define SRAP_LINEAR1_SEQUENCE_DELAYS 8'h0f
`define SRAP_OUTPUT1_SEQUENCE_DELAYS 8'h10
`define SRAP_OUTPUT2_SEQUENCE_DELAYS 8'h11
`define SRAP_GENERAL_OUTPUTS_CONTROL 8'h12
`define SRAP_GLOBAL_SETUP 8'h13
`define SRAP_CLOCK_SYNC_LOOP_CONTROL 8'h14
`define SRAP_REG_COUNT 21

// Per-register byte fields, register 0x00 in the low byte
`define SRAP_WR_MASK 168'h5f7f77ffffffffffff1f1f0707ffff3f0f3f1f0000
`define SRAP_OTP_MASK 168'h5f7f77ffffffffffff1f1f0707ffff3f0f3f1fffc0
`define SRAP_FIXED_DEFAULT 168'h02

// Link framing
`define SRAP_BITS_PER_BYTE 4'h8
`define SRAP_DIR_READ 1'b1

`endif

// ===== srap_pkg.sv
// Types shared by the serial register access port.
// Assumes srap_cfg.svh is on the include path.
package srap_pkg;
   `include "srap_cfg.svh"

   typedef logic [7:0] srap_byte_t;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEV  = 7'h02,
      ST_REG  = 7'h04,
      ST_WR   = 7'h08,
      ST_ACK  = 7'h10,
      ST_RD   = 7'h20,
      ST_MACK = 7'h40
   } srap_state_e;
endpackage

// ===== srap_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to clock_i.
module srap_pin_sync #(
   parameter logic IDLE_LEVEL = 1'b1
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Pin and filtered level
   input wire logic pin_i,
   output logic level_o
);
   logic ff1_q;
   logic ff2_q;
   logic ff3_q;
   logic level_q;
   logic agree;

   // Only ff2 reads ff1; the filter looks at stages two and three
   assign agree = (ff2_q == ff3_q);
   assign level_o = level_q;

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         ff1_q <= IDLE_LEVEL;
         ff2_q <= IDLE_LEVEL;
         ff3_q <= IDLE_LEVEL;
         level_q <= IDLE_LEVEL;
      end
      else
      begin
         ff1_q <= pin_i;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         if (agree)
            level_q <= ff3_q;
      end
   end
endmodule

// ===== srap_core.sv
// Two-wire serial slave holding the control register bank 0x00..0x14.
// Assumes open-drain lines resolved outside; fuse image valid at power-up.
`include "srap_cfg.svh"
module srap_core
   import srap_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h60,
   parameter int REG_COUNT = `SRAP_REG_COUNT
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic srst_i,
   // Serial link
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Supply monitor and fuse image
   input wire logic analog_supply_i,
   input wire logic [8*`SRAP_REG_COUNT-1:0] otp_image_i,
   // Register contents towards the regulators
   output logic [8*`SRAP_REG_COUNT-1:0] reg_image_o,
   output logic standby_o
);
   localparam logic [7:0] LAST_REG = `SRAP_CLOCK_SYNC_LOOP_CONTROL;
   localparam logic [8*`SRAP_REG_COUNT-1:0] WR_MASK = `SRAP_WR_MASK;
   localparam logic [8*`SRAP_REG_COUNT-1:0] OTP_MASK = `SRAP_OTP_MASK;
   localparam logic [8*`SRAP_REG_COUNT-1:0] FIXED = `SRAP_FIXED_DEFAULT;

   // Map is fixed by the masks; other sizes have no meaning
   generate
      if (REG_COUNT != `SRAP_REG_COUNT)
      begin : g_bad_count
         $error("srap_core: REG_COUNT must match the register map");
      end
      if (DEV_ADDR < 7'h08 || DEV_ADDR > 7'h77)
      begin : g_bad_addr
         $error("srap_core: DEV_ADDR lies in a reserved address range");
      end
   endgenerate

   function automatic srap_byte_t pick(
      input logic [8*`SRAP_REG_COUNT-1:0] v,
      input int i
   );
      pick = v[i*8 +: 8];
   endfunction

   // Fuse bits where the mask says so, fixed defaults elsewhere
   function automatic srap_byte_t boot_val(
      input logic [8*`SRAP_REG_COUNT-1:0] otp,
      input int i
   );
      boot_val = (pick(otp, i) & pick(OTP_MASK, i)) |
                 (pick(FIXED, i) & ~pick(OTP_MASK, i));
   endfunction

   // Synchronised pins
   logic scl_s;
   logic sda_s;
   logic supply_s;

   srap_pin_sync #(.IDLE_LEVEL(1'b1)) u_scl_sync (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .pin_i(scl_i),
      .level_o(scl_s)
   );

   srap_pin_sync #(.IDLE_LEVEL(1'b1)) u_sda_sync (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .pin_i(sda_i),
      .level_o(sda_s)
   );

   srap_pin_sync #(.IDLE_LEVEL(1'b0)) u_supply_sync (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .pin_i(analog_supply_i),
      .level_o(supply_s)
   );

   // State
   srap_state_e state_q;
   srap_state_e state_d;
   srap_state_e nxt_q;
   srap_state_e nxt_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   srap_byte_t shreg_q;
   srap_byte_t shreg_d;
   srap_byte_t idx_q;
   srap_byte_t idx_d;
   logic drive_q;
   logic drive_d;
   logic scl_prev_q;
   logic sda_prev_q;
   logic supply_on_q;
   srap_byte_t reg_q [`SRAP_REG_COUNT];

   // Line events
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic byte_done;
   logic rx_state;
   logic addr_match;
   logic idx_valid;
   logic wr_en;
   logic load_otp;
   srap_byte_t rd_byte;

   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign rx_state = (state_q == ST_DEV) || (state_q == ST_REG) ||
                     (state_q == ST_WR);
   assign byte_done = rx_state & scl_fall &
                      (cnt_q == `SRAP_BITS_PER_BYTE);
   assign addr_match = (shreg_q[7:1] == DEV_ADDR);
   assign idx_valid = (idx_q <= LAST_REG);
   assign wr_en = byte_done & (state_q == ST_WR) & idx_valid;
   // Out-of-map index reads as zero rather than aliasing
   assign rd_byte = idx_valid ? reg_q[int'(idx_q)] : 8'h00;
   assign load_otp = supply_s & ~supply_on_q;

   always_comb
   begin
      state_d = state_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      shreg_d = shreg_q;
      idx_d = idx_q;
      drive_d = drive_q;
      if (!supply_on_q || !supply_s)
      begin
         // Release with the supply drop, not a cycle after standby falls
         state_d = ST_IDLE;
         drive_d = 1'b0;
      end
      else if (start_det)
      begin
         state_d = ST_DEV;
         cnt_d = 4'h0;
         drive_d = 1'b0;
      end
      else if (stop_det)
      begin
         state_d = ST_IDLE;
         drive_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               drive_d = 1'b0;
            end
            ST_DEV, ST_REG, ST_WR:
            begin
               if (scl_rise)
               begin
                  shreg_d = {shreg_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (byte_done)
               begin
                  cnt_d = 4'h0;
                  state_d = ST_ACK;
                  drive_d = 1'b1;
                  if (state_q == ST_DEV)
                  begin
                     if (!addr_match)
                     begin
                        state_d = ST_IDLE;
                        drive_d = 1'b0;
                     end
                     else if (shreg_q[0] == `SRAP_DIR_READ)
                        nxt_d = ST_RD;
                     else
                        nxt_d = ST_REG;
                  end
                  else if (state_q == ST_REG)
                  begin
                     idx_d = shreg_q;
                     nxt_d = ST_WR;
                  end
                  else
                  begin
                     // Ignored bytes past the map are still acknowledged
                     idx_d = idx_q + 8'h01;
                     nxt_d = ST_WR;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_d = 4'h0;
                  state_d = nxt_q;
                  if (nxt_q == ST_RD)
                  begin
                     drive_d = ~rd_byte[7];
                     shreg_d = {rd_byte[6:0], 1'b0};
                  end
                  else
                     drive_d = 1'b0;
               end
            end
            ST_RD:
            begin
               if (scl_rise)
                  cnt_d = cnt_q + 4'h1;
               else if (scl_fall)
               begin
                  if (cnt_q == `SRAP_BITS_PER_BYTE)
                  begin
                     drive_d = 1'b0;
                     state_d = ST_MACK;
                  end
                  else
                  begin
                     drive_d = ~shreg_q[7];
                     shreg_d = {shreg_q[6:0], 1'b0};
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
               begin
                  if (sda_s)
                     state_d = ST_IDLE;
                  else
                  begin
                     // Same register again: index stays put
                     state_d = ST_ACK;
                     nxt_d = ST_RD;
                  end
               end
            end
            default:
            begin
               state_d = ST_IDLE;
               drive_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 4'h0;
         shreg_q <= 8'h00;
         idx_q <= 8'h00;
         drive_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         nxt_q <= nxt_d;
         cnt_q <= cnt_d;
         shreg_q <= shreg_d;
         idx_q <= idx_d;
         drive_q <= drive_d;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         supply_on_q <= 1'b0;
      end
      else
      begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         supply_on_q <= supply_s;
      end
   end

   // Register bank; supply loss returns to fixed defaults
   always_ff @(posedge clock_i)
   begin
      for (int i = 0; i < `SRAP_REG_COUNT; i++)
      begin
         if (srst_i || !supply_s)
            reg_q[i] <= pick(FIXED, i);
         else if (load_otp)
            reg_q[i] <= boot_val(otp_image_i, i);
         else if (wr_en && (int'(idx_q) == i))
            reg_q[i] <= (shreg_q & pick(WR_MASK, i)) |
                        (reg_q[i] & ~pick(WR_MASK, i));
      end
   end

   generate
      for (genvar g = 0; g < `SRAP_REG_COUNT; g++)
      begin : g_image
         assign reg_image_o[g*8 +: 8] = reg_q[g];
      end
   endgenerate

   // Open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~drive_q;
   assign standby_o = supply_on_q;
endmodule

// ===== srap_core_asserts.sv
// Checker for the register port's pins and register image.
// Assumes it is bound onto srap_core; one clock domain only.
`include "srap_cfg.svh"
module srap_core_asserts
   import srap_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h60,
   parameter int REG_COUNT = `SRAP_REG_COUNT
) (
   // Clock, reset and link
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   // Supply, fuses and registers
   input wire logic analog_supply_i,
   input wire logic [8*`SRAP_REG_COUNT-1:0] otp_image_i,
   input wire logic [8*`SRAP_REG_COUNT-1:0] reg_image_o,
   input wire logic standby_o
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [8*`SRAP_REG_COUNT-1:0] OM = `SRAP_OTP_MASK;
   localparam logic [8*`SRAP_REG_COUNT-1:0] FIX = `SRAP_FIXED_DEFAULT;
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   sequence s_ack_held;
      !sda_oe_n_o [*8];
   endsequence
   sequence s_quiet;
      sda_oe_n_o && !standby_o;
   endsequence
   a_pin_open_drain: assert property (sda_o == 1'b0)
      else $error("data pin value not low");
   a_ack_stands: assert property ($fell(sda_oe_n_o) |-> s_ack_held)
      else $error("pull-down too short");
   a_supply_quiet: assert property
      ($fell(analog_supply_i) |-> ##[1:8] s_quiet)
      else $error("still active after supply loss");
   a_drive_in_sb: assert property (!sda_oe_n_o |-> standby_o)
      else $error("driving data outside standby");
   a_fixed_bits: assert property
      ((reg_image_o & ~OM) == (FIX & ~OM))
      else $error("fixed bits differ");
   a_fuse_loaded: assert property
      ($rose(standby_o) |-> (reg_image_o & OM) == (otp_image_i & OM))
      else $error("fuse bits not loaded");
   a_reset_image: assert property
      ($fell(srst_i) |-> reg_image_o == FIX && !standby_o)
      else $error("reset image wrong");
   a_ro_stable: assert property
      ($past(standby_o) && standby_o |-> $stable(reg_image_o[15:0]))
      else $error("read-only register changed");
   a_write_scl_low: assert property
      ($past(standby_o) && standby_o && !$stable(reg_image_o) |-> !scl_i)
      else $error("register changed with clock high");
   a_drive_scl_low: assert property
      (analog_supply_i && $changed(sda_oe_n_o) |-> !scl_i)
      else $error("data drive changed with clock high");
endmodule

// ===== srap_host_model.sv
// Bus master model: bit-banged link at a 160 ns clock period.
// Assumes the bench resolves the data wire with a pull-up.
module srap_host_model
   import srap_pkg::*;
(
   // Link pins
   output logic scl_o,
   output logic sda_rel_o,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // Quarter period; raised by the bench for a slow master
   int q = 40;
   initial
   begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   // Data moves at mid-low only, sampled at mid-high
   task automatic bit_io(input logic b, output logic r);
      #q sda_rel_o = b;
      #q scl_o = 1'b1;
      #q r = sda_i;
      #q scl_o = 1'b0;
   endtask
   task automatic send(input srap_byte_t d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask
   task automatic get(input logic m, output srap_byte_t d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(m, r);
   endtask
   task automatic open(input logic [6:0] a, input logic rd, output logic ack);
      sda_rel_o = 1'b1;
      #q sda_rel_o = 1'b0;
      #q scl_o = 1'b0;
      send({a, rd}, ack);
   endtask
   task automatic stop();
      #q sda_rel_o = 1'b0;
      #q scl_o = 1'b1;
      #q sda_rel_o = 1'b1;
      #q;
   endtask
endmodule

// ===== serial_register_access_port_tb.sv
// Bench of the serial register access port against a bus master model.
// Assumes srap_pkg, srap_core, the model and the checker compiled first.
`include "srap_cfg.svh"
module serial_register_access_port_tb
   import srap_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [6:0] DEV = 7'h60;
   localparam int N = `SRAP_REG_COUNT;
   typedef logic [8*N-1:0] srap_image_t;
   localparam srap_image_t OTP_IMG = {N{8'ha5}};
   localparam srap_image_t WR = `SRAP_WR_MASK;
   localparam srap_image_t OM = `SRAP_OTP_MASK;
   localparam srap_image_t FIX = `SRAP_FIXED_DEFAULT;
   logic clock_i = 1'b0;
   logic srst_i = 1'b1;
   logic supply = 1'b1;
   logic scl, sda_rel, sda, sda_o, oe_n, standby;
   srap_image_t image, exp_q;
   int fails = 0;
   int compares = 0;
   always #5 clock_i = ~clock_i;
   // Pull-up wire
   assign sda = sda_rel & (oe_n | sda_o);
   srap_host_model u_srap_host_model (.scl_o(scl), .sda_rel_o(sda_rel),
      .sda_i(sda));
   srap_core #(.DEV_ADDR(DEV)) u_srap_core (.clock_i(clock_i),
      .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe_n_o(oe_n), .analog_supply_i(supply), .otp_image_i(OTP_IMG),
      .reg_image_o(image), .standby_o(standby));
   task automatic chk(input srap_image_t got, input srap_image_t want);
      compares++;
      if (got !== want)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, want);
         fails++;
      end
   endtask
   task automatic wrap_up();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wait_sb();
      for (int i = 0; i < 200 && standby !== 1'b1; i++)
         @(negedge clock_i);
      if (standby !== 1'b1)
      begin
         fails++;
         wrap_up();
      end
   endtask
   task automatic wr(input srap_byte_t idx, input srap_byte_t d, input int n);
      logic a;
      int j;
      @(negedge clock_i);
      u_srap_host_model.open(DEV, 1'b0, a);
      chk(a, 0);
      u_srap_host_model.send(idx, a);
      chk(a, 0);
      for (int k = 0; k < n; k++)
      begin
         u_srap_host_model.send(d + 8'(k), a);
         chk(a, 0);
         j = idx + k;
         if (j < N)
            exp_q[8*j+:8] = (exp_q[8*j+:8] & ~WR[8*j+:8]) |
               ((d + 8'(k)) & WR[8*j+:8]);
      end
      u_srap_host_model.stop();
      chk(image, exp_q);
   endtask
   task automatic rd(input srap_byte_t idx, input int n);
      logic a;
      srap_byte_t v;
      wr(idx, 8'h00, 0);
      u_srap_host_model.open(DEV, 1'b1, a);
      chk(a, 0);
      for (int k = 0; k < n; k++)
      begin
         u_srap_host_model.get(k == n - 1, v);
         chk(v, idx < N ? exp_q[8*idx+:8] : 8'h00);
      end
      u_srap_host_model.stop();
   endtask
   task automatic sc_power_up();
      wait_sb();
      exp_q = (OTP_IMG & OM) | (FIX & ~OM);
      chk(image, exp_q);
   endtask
   task automatic sc_bad_addr();
      logic a;
      @(negedge clock_i);
      u_srap_host_model.open(DEV ^ 7'h01, 1'b0, a);
      chk(a, 1);
      u_srap_host_model.send(8'h03, a);
      chk(a, 1);
      u_srap_host_model.stop();
      chk(image, exp_q);
   endtask
   task automatic sc_supply();
      logic a;
      @(negedge clock_i);
      supply = 1'b0;
      repeat (12) @(negedge clock_i);
      chk(image, FIX);
      chk(standby, 0);
      u_srap_host_model.open(DEV, 1'b0, a);
      chk(a, 1);
      u_srap_host_model.stop();
      supply = 1'b1;
      sc_power_up();
   endtask
   initial
   begin
      repeat (16) @(negedge clock_i);
      srst_i = 1'b0;
      sc_power_up();
      wr(8'h02, 8'h31, 5);
      wr(8'h13, 8'h0f, 3);
      wr(8'h00, 8'hff, 2);
      u_srap_host_model.q = 60;
      wr(8'h0c, 8'h7e, 2);
      u_srap_host_model.q = 40;
      rd(8'h05, 3);
      rd(8'h14, 1);
      rd(8'h15, 1);
      sc_bad_addr();
      sc_supply();
      rd(8'h03, 2);
      wrap_up();
   end
endmodule
bind srap_core srap_core_asserts #(.DEV_ADDR(DEV_ADDR),
   .REG_COUNT(REG_COUNT)) u_srap_core_asserts (.clock_i(clock_i),
   .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .analog_supply_i(analog_supply_i),
   .otp_image_i(otp_image_i), .reg_image_o(reg_image_o),
   .standby_o(standby_o));
